// ### design/iepu_top.sv
`timescale 1ns/1ps
`include "iepu_regs.svh"

// Notes on behaviour
// R01: Master gate bit 7 clear means no interrupt reaches the core.
// R02: Primary enable bits 6..0: ADC, T2, UART, T1, EXT1, T0, EXT0.
// R03: Secondary enable bits 5..0: CMP, touch, EXT2, base timer, PWM, serial.
// R04: Enabled PWM source requests on PWM counter overflow flag.
// R05: Primary level bits 6..0 pick high or low; bit 7 reserved.
// R06: Secondary level bits 5..0 pick high or low; bits 7..6 reserved.
// R07: High preempts running low; same level never preempts.
// R08: Equal level ties go to the smallest query number.
// R09: Blocked requests stay pending and are served after return.
// R10: Request needs flag, own enable and master gate, every cycle.
module iepu_top (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [9:0]          paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  input  wire iepu_pkg::iepu_src_t flags_in,
  input  wire logic                ack_in,
  input  wire logic                reti_in,
  output logic                     req_out,
  output iepu_pkg::iepu_num_t      req_num_out,
  output logic                     req_high_out,
  output logic                     irq_out
);
  import iepu_pkg::*;

  // Map the two register bytes onto query order
  function automatic iepu_src_t to_src(input logic [7:0] pri,
                                       input logic [7:0] sec);
    return {sec[`IEPU_SEC_MSB:0], pri[`IEPU_PRI_MSB:0]};
  endfunction : to_src

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  en_pri_ff;
  logic [7:0]  en_sec_ff;
  logic [7:0]  lvl_pri_ff;
  logic [7:0]  lvl_sec_ff;
  iepu_src_t   stat_ff;
  iepu_src_t   mask_ff;
  iepu_src_t   gated_prev_ff;
  iepu_src_t   lvl_prev_ff;
  iepu_svc_t   svc_ff;
  logic        req_ff;
  iepu_num_t   num_ff;
  logic        high_ff;
  logic        irq_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  ////////////////////////////////////////////////////////////////////////////
  wire [7:0] idx      = paddr_in[9:2];
  wire       setup    = psel_in & ~penable_in;
  wire       done     = psel_in & penable_in & pready_ff;
  wire       wr_done  = done & pwrite_in & ~pslverr_ff;
  wire       rd_done  = done & ~pwrite_in & ~pslverr_ff;
  wire       aligned  = (paddr_in[1:0] == 2'b00);
  wire       hit_enp  = aligned & (idx == `IEPU_IDX_EN_PRI);
  wire       hit_ens  = aligned & (idx == `IEPU_IDX_EN_SEC);
  wire       hit_lvp  = aligned & (idx == `IEPU_IDX_LVL_PRI);
  wire       hit_lvs  = aligned & (idx == `IEPU_IDX_LVL_SEC);
  wire       hit_stat = aligned & (idx == `IEPU_IDX_STAT);
  wire       hit_mask = aligned & (idx == `IEPU_IDX_MASK);
  wire       hit_svc  = aligned & (idx == `IEPU_IDX_SVC);
  wire       mapped   = hit_enp | hit_ens | hit_lvp | hit_lvs |
                        hit_stat | hit_mask | hit_svc;

  // Reserved bits read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_enp) begin
      rd_mux[7:0] = en_pri_ff;
    end else if (hit_ens) begin
      rd_mux[5:0] = en_sec_ff[5:0];
    end else if (hit_lvp) begin
      rd_mux[6:0] = lvl_pri_ff[6:0];
    end else if (hit_lvs) begin
      rd_mux[5:0] = lvl_sec_ff[5:0];
    end else if (hit_stat) begin
      rd_mux[12:0] = stat_ff;
    end else if (hit_mask) begin
      rd_mux[12:0] = mask_ff;
    end else if (hit_svc) begin
      rd_mux[1:0] = svc_ff;
      rd_mux[2]   = req_ff;
      rd_mux[3]   = high_ff;
      rd_mux[7:4] = num_ff;
    end
  end

  wire [7:0] nxt_en_pri  = wr_done & hit_enp ? pwdata_in[7:0] : en_pri_ff;
  wire [7:0] nxt_en_sec  = wr_done & hit_ens ?
                           {2'b00, pwdata_in[5:0]} : en_sec_ff;
  wire [7:0] nxt_lvl_pri = wr_done & hit_lvp ?
                           {1'b0, pwdata_in[6:0]} : lvl_pri_ff;
  wire [7:0] nxt_lvl_sec = wr_done & hit_lvs ?
                           {2'b00, pwdata_in[5:0]} : lvl_sec_ff;
  wire iepu_src_t nxt_mask = wr_done & hit_mask ?
                             pwdata_in[12:0] : mask_ff;

  // One wait-free access phase, answer set up in the setup cycle
  wire        nxt_pready  = setup;
  wire        nxt_pslverr = setup & ~mapped;
  wire [31:0] nxt_prdata  = setup & ~pwrite_in ? rd_mux : prdata_ff;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      en_pri_ff  <= `IEPU_RST_BYTE;
      en_sec_ff  <= `IEPU_RST_BYTE;
      lvl_pri_ff <= `IEPU_RST_BYTE;
      lvl_sec_ff <= `IEPU_RST_BYTE;
      mask_ff    <= `IEPU_RST_SRC;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      en_pri_ff  <= nxt_en_pri;
      en_sec_ff  <= nxt_en_sec;
      lvl_pri_ff <= nxt_lvl_pri;
      lvl_sec_ff <= nxt_lvl_sec;
      mask_ff    <= nxt_mask;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source gating
  ////////////////////////////////////////////////////////////////////////////
  // R01 master gate
  wire       gate   = en_pri_ff[`IEPU_GATE_BIT];
  // R02 R03 per-source enables
  wire iepu_src_t en_vec = to_src(en_pri_ff, en_sec_ff);
  // R05 R06 per-source levels
  wire iepu_src_t lvl_vec = to_src(lvl_pri_ff, lvl_sec_ff);
  // R10 flag, enable and gate
  wire iepu_src_t gated = flags_in & en_vec & {13{gate}};

  ////////////////////////////////////////////////////////////////////////////
  // Nesting state and arbitration
  ////////////////////////////////////////////////////////////////////////////
  // R07 same level blocked
  wire allow_hi = (svc_ff == IEPU_IDLE) | (svc_ff == IEPU_LOW);
  wire allow_lo = (svc_ff == IEPU_IDLE);
  wire taken    = ack_in & req_ff;

  wire       arb_valid;
  iepu_num_t arb_num;
  wire       arb_high;

  // R08 R09 lowest number wins within a level, losers stay pending
  iepu_arb u_arb (
    .req_in      (gated),
    .lvl_in      (lvl_vec),
    .allow_hi_in (allow_hi),
    .allow_lo_in (allow_lo),
    .valid_out   (arb_valid),
    .num_out     (arb_num),
    .high_out    (arb_high)
  );

  // R07 nesting of two levels
  iepu_svc_t nxt_svc;
  always_comb begin
    nxt_svc = svc_ff;
    case (svc_ff)
      IEPU_IDLE: begin
        if (taken) begin
          nxt_svc = high_ff ? IEPU_HIGH : IEPU_LOW;
        end
      end
      IEPU_LOW: begin
        if (taken & high_ff) begin
          nxt_svc = IEPU_BOTH;
        end else if (reti_in) begin
          nxt_svc = IEPU_IDLE;
        end
      end
      IEPU_BOTH: begin
        if (reti_in) begin
          nxt_svc = IEPU_LOW;
        end
      end
      IEPU_HIGH: begin
        if (reti_in) begin
          nxt_svc = IEPU_IDLE;
        end
      end
      default: begin
        nxt_svc = IEPU_IDLE;
      end
    endcase
  end

  // Hold request off for the cycle after the core takes it
  wire       nxt_req  = arb_valid & ~taken;
  wire       nxt_high = arb_high & ~taken;

  ////////////////////////////////////////////////////////////////////////////
  // Event status and interrupt output
  ////////////////////////////////////////////////////////////////////////////
  // R04 rise of a gated request, PWM overflow among them
  wire iepu_src_t events   = gated & ~gated_prev_ff;
  // Clear only what the read returned
  wire iepu_src_t stat_clr = rd_done & hit_stat ? prdata_ff[12:0] :
                                                  `IEPU_RST_SRC;
  // Set wins over read clear
  wire iepu_src_t nxt_stat = (stat_ff & ~stat_clr) | events;
  wire            nxt_irq  = |(nxt_stat & mask_ff);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      svc_ff        <= IEPU_IDLE;
      req_ff        <= 1'b0;
      num_ff        <= 4'h0;
      high_ff       <= 1'b0;
      stat_ff       <= `IEPU_RST_SRC;
      irq_ff        <= 1'b0;
      gated_prev_ff <= `IEPU_RST_SRC;
      lvl_prev_ff   <= `IEPU_RST_SRC;
    end else begin
      svc_ff        <= nxt_svc;
      req_ff        <= nxt_req;
      num_ff        <= arb_num;
      high_ff       <= nxt_high;
      stat_ff       <= nxt_stat;
      irq_ff        <= nxt_irq;
      gated_prev_ff <= gated;
      lvl_prev_ff   <= lvl_vec;
    end
  end

  assign prdata_out   = prdata_ff;
  assign pready_out   = pready_ff;
  assign pslverr_out  = pslverr_ff;
  assign req_out      = req_ff;
  assign req_num_out  = num_ff;
  assign req_high_out = high_ff;
  assign irq_out      = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  wire iepu_src_t same_lvl  = high_ff ? lvl_prev_ff : ~lvl_prev_ff;
  wire iepu_src_t below_num = (13'h0001 << num_ff) - 13'h0001;
  wire            hi_pend   = |(gated & lvl_vec);
  wire            lo_pend   = |(gated & ~lvl_vec);

  a_gate_off_quiet: // R01
    assert property (!gate && !$past(gate) |=> !req_ff)
    else $error("request shown while master gate is off");

  a_req_has_cause: // R10
    assert property (req_ff |-> gated_prev_ff[num_ff])
    else $error("request without flag, enable and gate");

  a_enable_bits_map: // R02
    assert property (req_ff |-> |($past(en_vec) & (13'h0001 << num_ff)) &&
                     $past(en_pri_ff[`IEPU_GATE_BIT]))
    else $error("request from a disabled source");

  a_sec_enable_map: // R03
    assert property (!en_sec_ff[0] && !$past(en_sec_ff[0])
                     |=> !(req_ff && num_ff == 4'h7))
    else $error("serial port request while disabled");

  a_pwm_overflow: // R04
    assert property ($rose(gated[`IEPU_PWM_SRC]) |=>
                     stat_ff[`IEPU_PWM_SRC])
    else $error("pwm overflow not recorded");

  a_level_follows: // R05
    assert property (req_ff |-> high_ff == lvl_prev_ff[num_ff])
    else $error("request level differs from level bit");

  a_sec_reserved: // R06
    assert property (lvl_sec_ff[7:6] == 2'b00 && lvl_pri_ff[7] == 1'b0)
    else $error("reserved level bits not zero");

  a_no_same_preempt: // R07
    assert property (svc_ff == IEPU_HIGH || svc_ff == IEPU_BOTH
                     |=> !req_ff)
    else $error("request while high service runs");

  a_high_preempts: // R07
    assert property (svc_ff == IEPU_LOW && hi_pend && !taken
                     |=> req_ff && high_ff)
    else $error("high request did not preempt low service");

  a_lowest_first: // R08
    assert property (req_ff |-> (gated_prev_ff & same_lvl & below_num)
                     == 13'h0000)
    else $error("larger query number granted first");

  a_pending_kept: // R09
    assert property ((svc_ff == IEPU_LOW && lo_pend && !hi_pend)
                     ##1 (svc_ff == IEPU_IDLE && lo_pend) |=> req_ff)
    else $error("pending request lost after return");

  a_apb_answer: // APB answer one cycle after setup, no rule
    assert property (setup |=> pready_ff ##1 !pready_ff)
    else $error("bus answer not one cycle after setup");

endmodule : iepu_top

// ### inc/iepu_regs.svh
`ifndef IEPU_REGS_SVH
`define IEPU_REGS_SVH

// Register indices, byte address is four times the index
`define IEPU_IDX_EN_PRI   8'hA8
`define IEPU_IDX_EN_SEC   8'hA9
`define IEPU_IDX_LVL_PRI  8'hB8
`define IEPU_IDX_LVL_SEC  8'hB9
`define IEPU_IDX_STAT     8'hC0
`define IEPU_IDX_MASK     8'hC1
`define IEPU_IDX_SVC      8'hC2

// Field positions and widths
`define IEPU_GATE_BIT     7
`define IEPU_PRI_MSB      6
`define IEPU_SEC_MSB      5
`define IEPU_NSRC         13
`define IEPU_PWM_SRC      8

// Reset values
`define IEPU_RST_BYTE     8'h00
`define IEPU_RST_SRC      13'h0000

`endif

// ### inc/iepu_pkg.sv
package iepu_pkg;

  // Service nesting, Gray coded along idle-low-both-high
  typedef enum logic [1:0] {
    IEPU_IDLE = 2'b00,
    IEPU_LOW  = 2'b01,
    IEPU_BOTH = 2'b11,
    IEPU_HIGH = 2'b10
  } iepu_svc_t;

  typedef logic [12:0] iepu_src_t;
  typedef logic [3:0]  iepu_num_t;

endpackage : iepu_pkg

// ### design/iepu_arb.sv
`timescale 1ns/1ps
module iepu_arb (
  input  wire iepu_pkg::iepu_src_t req_in,
  input  wire iepu_pkg::iepu_src_t lvl_in,
  input  wire logic                allow_hi_in,
  input  wire logic                allow_lo_in,
  output logic                     valid_out,
  output iepu_pkg::iepu_num_t      num_out,
  output logic                     high_out
);
  import iepu_pkg::*;

  // Lowest query number wins within a level
  function automatic iepu_num_t first_set(input iepu_src_t v);
    iepu_num_t n;
    n = 4'h0;
    for (int i = 12; i >= 0; i--) begin
      if (v[i]) begin
        n = i[3:0];
      end
    end
    return n;
  endfunction : first_set

  iepu_src_t hi_vec;
  iepu_src_t lo_vec;
  wire       hi_any;
  wire       lo_any;

  genvar g;
  generate
    for (g = 0; g < 13; g++) begin : g_split
      assign hi_vec[g] = req_in[g] & lvl_in[g];
      assign lo_vec[g] = req_in[g] & ~lvl_in[g];
    end
  endgenerate

  assign hi_any = |hi_vec;
  assign lo_any = |lo_vec;

  // High level first, then low
  assign high_out  = hi_any & allow_hi_in;
  assign valid_out = high_out | (lo_any & allow_lo_in);
  assign num_out   = high_out ? first_set(hi_vec) : first_set(lo_vec);

endmodule : iepu_arb

// ### test/iepu_core_model.sv
`timescale 1ns/1ps
module iepu_core_model (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire iepu_pkg::iepu_src_t set_in,
  input  wire logic                req_in,
  input  wire iepu_pkg::iepu_num_t num_in,
  input  wire logic [3:0]          wait_in,
  input  wire logic [3:0]          len_in,
  output iepu_pkg::iepu_src_t      flags_out,
  output logic                     ack_out,
  output logic                     reti_out
);
  import iepu_pkg::*;
  iepu_src_t  flags_ff;
  logic       ack_ff;
  logic       reti_ff;
  logic [3:0] wcnt_ff;
  logic [3:0] cnt_ff [2];
  logic [1:0] depth_ff;
  logic       take;
  assign take      = ack_ff & req_in;
  assign flags_out = flags_ff;
  assign ack_out   = ack_ff;
  assign reti_out  = reti_ff;
  ////////////////////////////////////////////////////////////////////
  // Sources set flags, service clears the taken one; nesting stack
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags_ff <= 13'h0000;
      ack_ff   <= 1'b0;
      reti_ff  <= 1'b0;
      wcnt_ff  <= 4'h0;
      depth_ff <= 2'h0;
      cnt_ff   <= '{4'h0, 4'h0};
    end else begin
      wcnt_ff  <= (req_in && !ack_ff) ? wcnt_ff + 4'h1 : 4'h0;
      ack_ff   <= req_in && !ack_ff && (wcnt_ff >= wait_in);
      flags_ff <= (flags_ff | set_in) & ~({12'h000, take} << num_in);
      reti_ff  <= 1'b0;
      if (take) begin
        cnt_ff[depth_ff[0]] <= len_in;
        depth_ff            <= depth_ff + 2'h1;
      end else if (depth_ff != 2'h0 && !reti_ff && !req_in) begin
        if (cnt_ff[depth_ff[1]] == 4'h0) begin
          reti_ff  <= 1'b1;
          depth_ff <= depth_ff - 2'h1;
        end else begin
          cnt_ff[depth_ff[1]] <= cnt_ff[depth_ff[1]] - 4'h1;
        end
      end
    end
  end
endmodule : iepu_core_model

// ### test/iepu_top_tb.sv
`timescale 1ns/1ps
`include "iepu_regs.svh"
module iepu_top_tb;
  import iepu_pkg::*;
  logic        clk, rst, psel, pen, pwr, pready, perr;
  logic        req, high, irq, ack, reti, err;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  iepu_src_t   flags, set, en, f, pend;
  iepu_num_t   num;
  logic [3:0]  wt, len;
  logic [15:0] lf;
  logic [7:0]  log_q [$];
  logic [7:0]  exp_q [$];
  int          failures, compares, cyc;
  logic [7:0]  idx [5] = '{`IEPU_IDX_EN_PRI, `IEPU_IDX_EN_SEC,
    `IEPU_IDX_LVL_PRI, `IEPU_IDX_LVL_SEC, `IEPU_IDX_MASK};
  logic [31:0] msk [5] = '{32'hFF, 32'h3F, 32'h7F, 32'h3F, 32'h1FFF};

  iepu_top i_iepu_top (.clk_in(clk), .rst_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(perr), .flags_in(flags), .ack_in(ack), .reti_in(reti),
    .req_out(req), .req_num_out(num), .req_high_out(high),
    .irq_out(irq));
  iepu_core_model i_iepu_core_model (.clk_in(clk), .rst_in(rst),
    .set_in(set), .req_in(req), .num_in(num), .wait_in(wt),
    .len_in(len), .flags_out(flags), .ack_out(ack), .reti_out(reti));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////
  // Event log of takes and returns, plus run limit
  always @(posedge clk) begin
    if (!rst && ack && req) log_q.push_back({3'h0, high, num});
    if (!rst && reti) log_q.push_back(8'hFF);
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= {a, 2'h0};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) failures++;
    rd  = prdata;
    err = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk(err, ee);
  endtask : rdc
  task automatic pulse(input iepu_src_t v);
    @(posedge clk);
    set <= v;
    @(posedge clk);
    set <= 13'h0000;
  endtask : pulse
  task automatic chk_log();
    int n;
    n = 0;
    while (log_q.size() < exp_q.size() && n < 900) begin
      @(posedge clk);
      n++;
    end
    repeat (24) @(posedge clk);
    chk(log_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < log_q.size()) chk(log_q[i], exp_q[i]);
    log_q.delete();
    exp_q.delete();
  endtask : chk_log
  task automatic end_of_test();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////
  initial begin
    {rst, psel, pen, pwr, paddr, pwdata} = {1'b1, 45'h0};
    {set, wt, len, failures, compares, cyc} = '0;
    lf = 16'h6181;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (idx[i]) rdc(idx[i], 32'h0, 1'b0);
    rdc(8'h00, 32'h0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      lf = nx(lf);
      apb(1'b1, idx[i], {lf, lf});
      rdc(idx[i], {lf, lf} & msk[i], 1'b0);
    end
    apb(1'b1, `IEPU_IDX_SVC, 32'hFFFFFFFF);
    rdc(`IEPU_IDX_SVC, 32'h0, 1'b0);
    foreach (idx[i]) apb(1'b1, idx[i], 32'h0);
    len <= 4'h2;
    pend = 13'h0000;
    for (int r = 0; r < 10; r++) begin
      lf = nx(lf);
      en = (r == 0 || r == 9) ? 13'h1FFF : r == 1 ? 13'h0100 :
           r == 2 ? 13'h0000 : lf[12:0];
      lf = nx(lf);
      f  = r < 2 ? 13'h1FFF : lf[12:0];
      wt <= {2'h0, lf[15:14]};
      apb(1'b1, `IEPU_IDX_EN_PRI, {25'h0, en[6:0]});
      apb(1'b1, `IEPU_IDX_EN_SEC, {26'h0, en[12:7]});
      pulse(f);
      pend = pend | f;
      repeat (5) @(posedge clk);
      chk(log_q.size(), 0);
      for (int b = 0; b < 13; b++) begin
        if (pend[b] && en[b]) exp_q.push_back(b[7:0]);
        if (pend[b] && en[b]) exp_q.push_back(8'hFF);
      end
      pend = pend & ~en;
      apb(1'b1, `IEPU_IDX_EN_PRI, {24'h0, 1'b1, en[6:0]});
      chk_log();
    end
    len <= 4'hF;
    wt  <= 4'h0;
    apb(1'b1, `IEPU_IDX_LVL_PRI, 32'h20);
    apb(1'b1, `IEPU_IDX_LVL_SEC, 32'h20);
    apb(1'b1, `IEPU_IDX_EN_SEC, 32'h3F);
    apb(1'b1, `IEPU_IDX_EN_PRI, 32'hFF);
    pulse(13'h0009);
    while (log_q.size() < 1) @(posedge clk);
    pulse(13'h1000);
    while (log_q.size() < 2) @(posedge clk);
    pulse(13'h0022);
    exp_q = '{8'h00, 8'h1C, 8'hFF, 8'h15, 8'hFF, 8'hFF, 8'h01, 8'hFF,
              8'h03, 8'hFF};
    chk_log();
    apb(1'b0, `IEPU_IDX_STAT, 32'h0);
    rdc(`IEPU_IDX_STAT, 32'h0, 1'b0);
    apb(1'b1, `IEPU_IDX_MASK, 32'h1);
    @(negedge clk);
    chk(irq, 1'b0);
    pulse(13'h0001);
    repeat (3) @(negedge clk);
    chk(irq, 1'b1);
    rdc(`IEPU_IDX_STAT, 32'h1, 1'b0);
    @(negedge clk);
    chk(irq, 1'b0);
    apb(1'b1, `IEPU_IDX_MASK, 32'h0);
    pulse(13'h0002);
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    rdc(`IEPU_IDX_STAT, 32'h2, 1'b0);
    exp_q = '{8'h00, 8'hFF, 8'h01, 8'hFF};
    chk_log();
    end_of_test();
  end
endmodule : iepu_top_tb
